// File: design/sce_cond_exec.sv
// conditional execution control for a dual-lane core
//
// Operation
// - second-lane explicit store gated by first-lane test
// - implicit store gated by second-lane test
// - implicit store at explicit address plus one or two
// - direct and indirect stores behave alike
// - address generator load when either lane true
// - branches and loops on AND of lanes
// - compute becomes no-op on non-branching lane
// - single lane: IF executes only when true
// - single lane: ELSE only when false
// - dual lane: ELSE per lane, IF both
// - direct branch type 8, indirect 9-11
// - compact set type ten is register add
`include "sce_regs.svh"
module sce_cond_exec #(
  parameter int ADDR_W = 32
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic VALID,
  input wire sce_pkg::sce_op_e OP,
  input wire logic [3:0] INSTR_TYPE,
  input wire logic HAS_ELSE,
  input wire logic COMPACT_SET,
  input wire logic SINGLE_LANE_MODE,
  input wire logic SHORT_WORD_SPACE,
  input wire logic DIRECT_ADDR,
  input wire sce_pkg::sce_src_e STORE_SRC,
  input wire logic [ADDR_W-1:0] INDEX_ADDR,
  input wire logic [ADDR_W-1:0] DIRECT_ADDR_VAL,
  input wire logic FIRST_LANE_TEST,
  input wire logic SECOND_LANE_TEST,
  output logic EXPL_STORE,
  output logic [ADDR_W-1:0] EXPL_ADDR,
  output logic IMPL_STORE,
  output logic [ADDR_W-1:0] IMPL_ADDR,
  output logic AGEN_LOAD,
  output logic BRANCH_TAKE,
  output logic FIRST_COMPUTE,
  output logic SECOND_COMPUTE,
  output logic FIRST_ELSE,
  output logic SECOND_ELSE,
  output logic REG_ADD,
  output logic ILLEGAL
);
  import sce_pkg::*;

  // the short-word offset of two needs at least two address bits
  if (ADDR_W < 2) begin : g_bad_width
    $error("ADDR_W too small");
  end

  // =========================================
  // state
  typedef struct packed {
    logic expl_store;
    logic [ADDR_W-1:0] expl_addr;
    logic impl_store;
    logic [ADDR_W-1:0] impl_addr;
    logic agen_load;
    logic branch_take;
    logic first_compute;
    logic second_compute;
    logic first_else;
    logic second_else;
    logic reg_add;
    logic illegal;
  } sce_state_s;

  sce_state_s st; // registered outputs
  sce_state_s next_st; // next value

  // =========================================
  // decision logic
  always_comb begin
    logic both; // AND of lane tests
    logic [ADDR_W-1:0] base; // effective address
    logic [ADDR_W-1:0] ofs; // implicit lane offset
    logic ind_type; // type carries indirect branch
    logic br_type; // any branch-capable type
    logic ta; // first lane test as applied
    logic tb; // second lane test as applied
    both = 1'b0;
    base = '0;
    ofs = '0;
    ind_type = 1'b0;
    br_type = 1'b0;
    next_st = '0;
    // single lane ignores second lane entirely
    ta = FIRST_LANE_TEST;
    tb = SINGLE_LANE_MODE ? FIRST_LANE_TEST : SECOND_LANE_TEST;
    both = ta & tb;
    // address mode does not change the gating
    base = DIRECT_ADDR ? DIRECT_ADDR_VAL : INDEX_ADDR;
    ofs = SHORT_WORD_SPACE ? ADDR_W'(`SCE_OFS_SHORT) :
      ADDR_W'(`SCE_OFS_NORMAL);
    ind_type = (INSTR_TYPE == `SCE_TYPE_IND_BR_A) ||
      (INSTR_TYPE == `SCE_TYPE_IND_BR_C) ||
      ((INSTR_TYPE == `SCE_TYPE_IND_BR_B) && !COMPACT_SET);
    br_type = ind_type || (INSTR_TYPE == `SCE_TYPE_DIRECT_BR);
    if (!VALID) begin
      // idle: nothing issued
    end else if (COMPACT_SET && INSTR_TYPE == `SCE_TYPE_IND_BR_B) begin
      next_st.reg_add = 1'b1;
    end else begin
      case (OP)
        SCE_OP_STORE: begin
          next_st.expl_addr = base;
          if (SINGLE_LANE_MODE) begin
            next_st.expl_store = ta;
          end else begin
            // explicit follows first lane for either source lane
            next_st.expl_store = ta;
            next_st.impl_store = tb;
            next_st.impl_addr = base + ofs;
          end
        end
        SCE_OP_AGEN_LOAD: begin
          next_st.agen_load = ta | tb;
        end
        SCE_OP_BRANCH, SCE_OP_LOOP: begin
          if (OP == SCE_OP_BRANCH && !br_type) begin
            next_st.illegal = 1'b1;
          end else if (HAS_ELSE && !ind_type) begin
            next_st.illegal = 1'b1;
          end else begin
            next_st.branch_take = both;
            // compute runs only on lanes that follow the branch
            next_st.first_compute = both;
            next_st.second_compute = both & !SINGLE_LANE_MODE;
            if (HAS_ELSE) begin
              next_st.first_else = !ta;
              next_st.second_else = !tb & !SINGLE_LANE_MODE;
            end
          end
        end
        default: begin
          // no conditional action
        end
      endcase
    end
  end

  // =========================================
  // state register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign EXPL_STORE = st.expl_store;
  assign EXPL_ADDR = st.expl_addr;
  assign IMPL_STORE = st.impl_store;
  assign IMPL_ADDR = st.impl_addr;
  assign AGEN_LOAD = st.agen_load;
  assign BRANCH_TAKE = st.branch_take;
  assign FIRST_COMPUTE = st.first_compute;
  assign SECOND_COMPUTE = st.second_compute;
  assign FIRST_ELSE = st.first_else;
  assign SECOND_ELSE = st.second_else;
  assign REG_ADD = st.reg_add;
  assign ILLEGAL = st.illegal;

  // =========================================
  // assertions
  // store gating per lane, held against the tests one edge back
  a_expl_first_lane: assert property (@(posedge CLOCK) disable iff (RST)
    EXPL_STORE |-> $past(FIRST_LANE_TEST))
    else $error("explicit store without first lane true");
  // a second-lane source must still follow the first lane test
  a_src_second: assert property (@(posedge CLOCK) disable iff (RST)
    $past(VALID && OP == SCE_OP_STORE && !SINGLE_LANE_MODE &&
      STORE_SRC == SCE_SRC_SECOND &&
      !(COMPACT_SET && INSTR_TYPE == `SCE_TYPE_IND_BR_B)) |->
      EXPL_STORE == $past(FIRST_LANE_TEST))
    else $error("second lane source not gated by first lane");
  a_impl_second_lane: assert property (@(posedge CLOCK) disable iff (RST)
    IMPL_STORE |-> $past(SECOND_LANE_TEST) && !$past(SINGLE_LANE_MODE))
    else $error("implicit store without second lane true");
  a_impl_offset: assert property (@(posedge CLOCK) disable iff (RST)
    IMPL_STORE |-> IMPL_ADDR == EXPL_ADDR + ($past(SHORT_WORD_SPACE) ?
      ADDR_W'(`SCE_OFS_SHORT) : ADDR_W'(`SCE_OFS_NORMAL)))
    else $error("implicit store offset wrong");
  a_direct_addr: assert property (@(posedge CLOCK) disable iff (RST)
    EXPL_STORE && $past(DIRECT_ADDR) |->
      EXPL_ADDR == $past(DIRECT_ADDR_VAL))
    else $error("direct store address wrong");
  a_agen_or: assert property (@(posedge CLOCK) disable iff (RST)
    $past(VALID && OP == SCE_OP_AGEN_LOAD && !SINGLE_LANE_MODE &&
      !(COMPACT_SET && INSTR_TYPE == `SCE_TYPE_IND_BR_B)) |->
      AGEN_LOAD == $past(FIRST_LANE_TEST | SECOND_LANE_TEST))
    else $error("address generator load gating wrong");
  // branch and compute decisions
  a_branch_and: assert property (@(posedge CLOCK) disable iff (RST)
    BRANCH_TAKE |-> $past(FIRST_LANE_TEST) &&
      ($past(SINGLE_LANE_MODE) || $past(SECOND_LANE_TEST)))
    else $error("branch taken without both lanes");
  a_compute_nop: assert property (@(posedge CLOCK) disable iff (RST)
    (FIRST_COMPUTE || SECOND_COMPUTE) |-> BRANCH_TAKE &&
      $past(FIRST_LANE_TEST) &&
      ($past(SINGLE_LANE_MODE) || $past(SECOND_LANE_TEST)))
    else $error("compute on non-branching lane");
  // single lane: the one test alone decides the branch
  a_single_if: assert property (@(posedge CLOCK) disable iff (RST)
    $past(VALID && SINGLE_LANE_MODE && OP == SCE_OP_BRANCH &&
      !COMPACT_SET && INSTR_TYPE > `SCE_TYPE_DIRECT_BR &&
      INSTR_TYPE <= `SCE_TYPE_IND_BR_C) |->
      BRANCH_TAKE == $past(FIRST_LANE_TEST))
    else $error("single lane branch not following its test");
  a_else_excl: assert property (@(posedge CLOCK) disable iff (RST)
    FIRST_ELSE |-> !BRANCH_TAKE && !$past(FIRST_LANE_TEST))
    else $error("else with true first lane");
  a_else_second: assert property (@(posedge CLOCK) disable iff (RST)
    SECOND_ELSE |-> !$past(SECOND_LANE_TEST) && !BRANCH_TAKE)
    else $error("second else with true lane");
  // decode checks: refused types do nothing but flag
  a_illegal_type: assert property (@(posedge CLOCK) disable iff (RST)
    $past(VALID && OP == SCE_OP_BRANCH && !COMPACT_SET &&
      (INSTR_TYPE < `SCE_TYPE_DIRECT_BR ||
      INSTR_TYPE > `SCE_TYPE_IND_BR_C)) |-> ILLEGAL && !BRANCH_TAKE)
    else $error("branch of unsupported type accepted");
  a_illegal_alone: assert property (@(posedge CLOCK) disable iff (RST)
    ILLEGAL |-> !BRANCH_TAKE && !FIRST_COMPUTE && !FIRST_ELSE &&
      !SECOND_ELSE)
    else $error("refused instruction still acted on");
  a_type_ten: assert property (@(posedge CLOCK) disable iff (RST)
    REG_ADD |-> !BRANCH_TAKE && !EXPL_STORE && !FIRST_ELSE)
    else $error("type ten decoded as branch");
  // main scenarios worth seeing at least once
  c_dual_store: cover property (@(posedge CLOCK) EXPL_STORE && IMPL_STORE);
  c_branch: cover property (@(posedge CLOCK) BRANCH_TAKE);
  c_split_else: cover property (@(posedge CLOCK) FIRST_ELSE && !SECOND_ELSE);
  c_reg_add: cover property (@(posedge CLOCK) REG_ADD);
  c_second_src: cover property (@(posedge CLOCK) disable iff (RST)
    EXPL_STORE && $past(STORE_SRC == SCE_SRC_SECOND));
endmodule

// File: design/sce_pkg.sv
// types of the conditional-execution block
package sce_pkg;
  // operation class presented by the decoder
  typedef enum logic [2:0] {
    SCE_OP_NONE,
    SCE_OP_STORE,
    SCE_OP_AGEN_LOAD,
    SCE_OP_BRANCH,
    SCE_OP_LOOP
  } sce_op_e;
  // explicit store source lane
  typedef enum logic {
    SCE_SRC_FIRST,
    SCE_SRC_SECOND
  } sce_src_e;
endpackage

// File: design/sce_regs.svh
// constants of the conditional-execution block
`ifndef SCE_REGS_SVH
`define SCE_REGS_SVH
// implicit lane address offset per word space
`define SCE_OFS_NORMAL 2'h1
`define SCE_OFS_SHORT 2'h2
// instruction type codes
`define SCE_TYPE_DIRECT_BR 4'h8
`define SCE_TYPE_IND_BR_A 4'h9
`define SCE_TYPE_IND_BR_B 4'ha
`define SCE_TYPE_IND_BR_C 4'hb
`endif

// File: testbench/sce_mem_model.sv
// memory-side model that counts the stores it accepts
module sce_mem_model (
  input wire logic CLOCK,
  input wire logic wr_a,
  input wire logic wr_b,
  output int n_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0; // stores accepted so far
  assign n_wr = cnt;
  // ===================================
  // write port: each strobe is one word
  always @(posedge CLOCK) begin
    cnt <= cnt + int'(wr_a) + int'(wr_b);
  end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the conditional-execution block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sce_pkg::*;
  localparam int NR = 21;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  sce_op_e op = SCE_OP_NONE;
  logic [3:0] ityp = 4'h0;
  // else, compact, single, short, direct, src, test1, test2
  logic [7:0] fl = 8'h00;
  logic [31:0] idx = 32'h64;
  logic [31:0] dva = 32'h200;
  logic [31:0] base;
  wire logic [9:0] got;
  wire logic [31:0] ea;
  wire logic [31:0] ia;
  int num_errors = 0;
  int n_tests = 0;
  int exp_wr = 0;
  int n_wr;
  // op, type, flags, then expected strobes; no complement-to-plain
  // peripheral move is ever issued here
  logic [24:0] rows [NR] = '{
    {3'h1, 4'h0, 8'h04, 10'h000}, {3'h1, 4'h0, 8'h06, 10'h200},
    {3'h1, 4'h0, 8'h15, 10'h100}, {3'h1, 4'h0, 8'h0b, 10'h300},
    {3'h1, 4'h0, 8'h23, 10'h200}, {3'h2, 4'h0, 8'h02, 10'h080},
    {3'h2, 4'h0, 8'h01, 10'h080}, {3'h2, 4'h0, 8'h00, 10'h000},
    {3'h3, 4'h8, 8'h03, 10'h070}, {3'h3, 4'h8, 8'h02, 10'h000},
    {3'h4, 4'h0, 8'h03, 10'h070}, {3'h4, 4'h0, 8'h01, 10'h000},
    {3'h3, 4'h9, 8'h82, 10'h004}, {3'h3, 4'hb, 8'h80, 10'h00c},
    {3'h3, 4'ha, 8'h83, 10'h070}, {3'h3, 4'h9, 8'ha0, 10'h008},
    {3'h3, 4'h9, 8'ha2, 10'h060}, {3'h3, 4'ha, 8'hc3, 10'h002},
    {3'h3, 4'h7, 8'h03, 10'h001}, {3'h3, 4'h8, 8'h83, 10'h001},
    {3'h0, 4'h0, 8'h03, 10'h000}};
  sce_cond_exec #(.ADDR_W(32)) i_sce_cond_exec (
    .CLOCK(clk), .RST(rst), .VALID(vld), .OP(op), .INSTR_TYPE(ityp),
    .HAS_ELSE(fl[7]), .COMPACT_SET(fl[6]), .SINGLE_LANE_MODE(fl[5]),
    .SHORT_WORD_SPACE(fl[4]), .DIRECT_ADDR(fl[3]),
    .STORE_SRC(sce_src_e'(fl[2])), .INDEX_ADDR(idx),
    .DIRECT_ADDR_VAL(dva), .FIRST_LANE_TEST(fl[1]),
    .SECOND_LANE_TEST(fl[0]), .EXPL_STORE(got[9]), .EXPL_ADDR(ea),
    .IMPL_STORE(got[8]), .IMPL_ADDR(ia), .AGEN_LOAD(got[7]),
    .BRANCH_TAKE(got[6]), .FIRST_COMPUTE(got[5]),
    .SECOND_COMPUTE(got[4]), .FIRST_ELSE(got[3]), .SECOND_ELSE(got[2]),
    .REG_ADD(got[1]), .ILLEGAL(got[0]));
  sce_mem_model i_sce_mem_model (
    .CLOCK(clk), .wr_a(got[9]), .wr_b(got[8]), .n_wr(n_wr));
  // ===================================
  // shared compare and closing tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string m);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ===================================
  // clock and watchdog
  always #25 clk = ~clk;
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
  // ===================================
  // main sequence: rows, then the awkward cases
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NR; i++) begin
      @(posedge clk);
      op <= sce_op_e'(rows[i][24:22]);
      ityp <= rows[i][21:18];
      fl <= rows[i][17:10];
      vld <= 1'b1;
      @(posedge clk);
      #1;
      chk(32'(got), 32'(rows[i][9:0]), "strobes");
      base = fl[3] ? dva : idx;
      if (rows[i][9]) chk(ea, base, "explicit address");
      if (rows[i][8]) chk(ia, base + (fl[4] ? 32'h2 : 32'h1), "offset");
      // each row is held for two sampling edges
      exp_wr += 2 * (int'(rows[i][9]) + int'(rows[i][8]));
      $display("row %0d done", i);
    end
    // store inputs with the instruction slot empty
    @(posedge clk);
    op <= SCE_OP_STORE;
    vld <= 1'b0;
    @(posedge clk);
    #1 chk(32'(got), 32'h0, "idle slot");
    $display("idle test done");
    // reset in mid-run drops the strobes at once
    @(posedge clk);
    vld <= 1'b1;
    @(posedge clk);
    #1 chk(32'(got), 32'h300, "store before reset");
    // both strobes stand one cycle before reset: two words land
    exp_wr += 2;
    @(posedge clk);
    rst <= 1'b1;
    #1 chk(32'(got), 32'h0, "in reset");
    @(posedge clk);
    rst <= 1'b0;
    vld <= 1'b0;
    @(posedge clk);
    #1 chk(32'(got), 32'h0, "after reset");
    @(posedge clk);
    #1 chk(32'(n_wr), 32'(exp_wr), "writes seen in memory");
    $display("reset test done");
    end_sim();
  end
endmodule
